// >>> hw/ctrl_field_reg.sv
`timescale 1ns/1ns
`include "servo_rf_cfg.svh"
module ctrl_field_reg
  import servo_rf_pkg::*;
#(
  parameter logic [3:0] SEL = `SEL_POWER,
  parameter field_word_t MASK = 12'hFFF,
  parameter field_word_t RESET = 12'h000
)
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic wr_in,
  input wire logic [15:0] word_in,
  output field_word_t fields_out
);
  generate
    if ((RESET & ~MASK) != 12'h000)
    begin : g_bad_reset
      $error("reset value sets bits outside the field mask");
    end
  endgenerate

  wire logic hit = wr_in && (word_in[`SEL_MSB:`SEL_LSB] == SEL);
  // Unused bits are dropped here so they can never reach an analog setting
  wire field_word_t fields_d = hit ? (word_in[`FIELD_MSB:0] & MASK)
                                   : fields_out;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      fields_out <= RESET;
    else
      fields_out <= fields_d;
  end
endmodule

// >>> hw/radial_mode_decode.sv
`timescale 1ns/1ns
module radial_mode_decode
  import servo_rf_pkg::*;
(
  input wire logic [2:0] code_in,
  output radial_mode_e mode_out
);
  always_comb
  begin
    case (code_in)
      3'b000: mode_out = TRACK_PHASE_AD;
      3'b001: mode_out = TRACK_PP_AD;
      3'b100: mode_out = TRACK_PHASE_SUM;
      3'b101: mode_out = TRACK_PP_FOUR;
      3'b110: mode_out = TRACK_PHASE_DUAL;
      3'b011: mode_out = TRACK_THREE_BEAM;
      3'b111: mode_out = TRACK_THREE_BEAM;
      default: mode_out = TRACK_UNDEFINED;
    endcase
  end
endmodule

// >>> hw/servo_rf_cfg.svh
`ifndef SERVO_RF_CFG_SVH
`define SERVO_RF_CFG_SVH

// Control word layout
`define SEL_MSB 15
`define SEL_LSB 12
`define FIELD_MSB 11
`define SEL_POWER 4'h0
`define SEL_MODE 4'h1
`define SEL_FOCUS 4'h2
`define SEL_GAIN 4'h3

// Register indices; byte address is four times the index
`define IDX_POWER 4'h0
`define IDX_MODE 4'h1
`define IDX_FOCUS 4'h2
`define IDX_GAIN 4'h3
`define IDX_CMD 4'h8
`define IDX_STATUS 4'h9

// Implemented field bits and reset values of each register
`define MASK_POWER 12'h00F
`define MASK_MODE 12'h93F
`define MASK_FOCUS 12'hFE0
`define MASK_GAIN 12'hFF0
`define RST_POWER 12'h000
`define RST_MODE 12'h100
`define RST_FOCUS 12'h400
`define RST_GAIN 12'h000

// Field positions
`define PWR_UP_BIT 0
`define PWR_LASER2_BIT 1
`define PWR_LASER1_BIT 2
`define PWR_MON2_BIT 3
`define MODE_RF_SEL_BIT 0
`define MODE_TRACK_LSB 1
`define MODE_TRACK_MSB 3
`define MODE_FOCUS4_BIT 4
`define MODE_DOC_BIT 5
`define MODE_POL_BIT 8
`define MODE_SRC_BIT 11
`define FOC_BETA_LSB 5
`define FOC_BETA_MSB 9
`define FOC_DAC_OFF_BIT 10
`define FOC_K2_BIT 11
`define G3_LSB 4
`define G3_MSB 7
`define G2_LSB 8
`define G2_MSB 9
`define G1_LSB 10
`define G1_MSB 11

// Stage gains in dB
`define G1_CODE_BAD 2'h3
`define G1_DB_0 5'h00
`define G1_DB_1 5'h06
`define G1_DB_2 5'h0C
`define G2_DB_0 5'h06
`define G2_DB_1 5'h0C
`define G2_DB_2 5'h12
`define G2_DB_3 5'h18

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STRB_WORD 2'h3

`endif

// >>> hw/servo_rf_control_regs.sv
// Notes on behaviour
// - Bits 15..12 select target register 0..3
// - Power bit 3 sets second monitor level
// - Power bits 2,1 switch the two lasers
// - Power bit 0 low means standby
// - Mode bit 11 picks phase offset source
// - Mode bit 8 radial polarity, normal default
// - Mode bit 5 enables drop-out concealment
// - Mode bit 4 picks two or four-channel focus
// - Mode bits 3..1 decode radial tracking mode
// - Mode bit 0 picks diode or summed RF
// - Focus bit 11 enables K2 compensation
// - Focus bit 10 low enables offset DAC
// - Focus bits 9..5 give factor n/32
// - Stage one gain 0/6/12 dB, code 3 forbidden
// - Stage two gain 6/12/18/24 dB
// - Summed RF with source 0 shares offset value
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "servo_rf_cfg.svh"
module servo_rf_control_regs
  import servo_rf_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [5:0] left_rf_offset_in,
  input wire logic [5:0] sum_rf_offset_in,
  output logic second_monitor_level_sel_out,
  output logic first_laser_enable_out,
  output logic second_laser_enable_out,
  output logic power_up_out,
  output logic phase_offset_src_sel_out,
  output logic radial_polarity_out,
  output logic dropout_conceal_en_out,
  output logic focus_four_channel_out,
  output radial_mode_e radial_track_sel_out,
  output logic rf_input_sel_out,
  output logic k_two_comp_en_out,
  output logic focus_dac_on_out,
  output logic [4:0] focus_comp_factor_out,
  output logic [4:0] rf_stage1_gain_db_out,
  output logic rf_stage1_code_bad_out,
  output logic [4:0] rf_stage2_gain_db_out,
  output logic [3:0] rf_stage3_gain_out,
  output logic [5:0] phase_offset_dac_out,
  output logic [5:0] sum_offset_dac_out
);
  generate
    if (ADDR_W < 6)
    begin : g_bad_addr
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  localparam int IDX_W = ADDR_W - 2;

  // Write channel: address and data are held until both are in, then
  // one cycle later the word is applied and the response raised.
  logic aw_hold_q, w_hold_q, bvalid_q, awready_q, wready_q;
  logic [IDX_W-1:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;

  wire logic aw_fire = s_axi_awvalid_in && awready_q;
  wire logic w_fire = s_axi_wvalid_in && wready_q;
  wire logic do_write = aw_hold_q && w_hold_q && !bvalid_q;
  wire logic aw_hold_d = aw_fire || (aw_hold_q && !do_write);
  wire logic w_hold_d = w_fire || (w_hold_q && !do_write);
  wire logic bvalid_d = do_write || (bvalid_q && !s_axi_bready_in);
  wire logic awready_d = !aw_hold_d && !bvalid_d;
  wire logic wready_d = !w_hold_d && !bvalid_d;
  wire logic [IDX_W-1:0] aw_idx_d = aw_fire ? s_axi_awaddr_in[ADDR_W-1:2] : aw_idx_q;
  wire logic [31:0] wdata_d = w_fire ? s_axi_wdata_in : wdata_q;
  wire logic [3:0] wstrb_d = w_fire ? s_axi_wstrb_in : wstrb_q;
  wire logic cmd_hit = (aw_idx_q == IDX_W'(`IDX_CMD));
  // A half-written word would mix old and new fields, so it is refused
  wire logic full_word = (wstrb_q[1:0] == `STRB_WORD);
  wire logic cmd_wr = do_write && cmd_hit && full_word;
  wire logic [1:0] bresp_d = do_write ? ((cmd_hit && full_word) ? `RESP_OKAY : `RESP_SLVERR)
                                      : bresp_q;
  wire logic [15:0] cmd_word = wdata_q[15:0];
  wire field_word_t cmd_fields = wdata_q[`FIELD_MSB:0];
  wire logic [3:0] cmd_sel = wdata_q[`SEL_MSB:`SEL_LSB];

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_idx_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      bvalid_q <= bvalid_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_idx_q <= aw_idx_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // Control registers; the selector routes the word to at most one of them, and selectors 4..15 reach none
  field_word_t pwr_f, mode_f, foc_f, gain_f;

  ctrl_field_reg #(.SEL(`SEL_POWER), .MASK(`MASK_POWER), .RESET(`RST_POWER)) u_power (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_in(cmd_wr),
    .word_in(cmd_word),
    .fields_out(pwr_f)
  );
  ctrl_field_reg #(.SEL(`SEL_MODE), .MASK(`MASK_MODE), .RESET(`RST_MODE)) u_mode (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_in(cmd_wr),
    .word_in(cmd_word),
    .fields_out(mode_f)
  );
  ctrl_field_reg #(.SEL(`SEL_FOCUS), .MASK(`MASK_FOCUS), .RESET(`RST_FOCUS)) u_focus (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_in(cmd_wr),
    .word_in(cmd_word),
    .fields_out(foc_f)
  );
  ctrl_field_reg #(.SEL(`SEL_GAIN), .MASK(`MASK_GAIN), .RESET(`RST_GAIN)) u_gain (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_in(cmd_wr),
    .word_in(cmd_word),
    .fields_out(gain_f)
  );

  // Plain field outputs come straight from the register flops
  assign second_monitor_level_sel_out = pwr_f[`PWR_MON2_BIT];
  assign first_laser_enable_out = pwr_f[`PWR_LASER1_BIT];
  assign second_laser_enable_out = pwr_f[`PWR_LASER2_BIT];
  assign power_up_out = pwr_f[`PWR_UP_BIT];
  assign phase_offset_src_sel_out = mode_f[`MODE_SRC_BIT];
  assign radial_polarity_out = mode_f[`MODE_POL_BIT];
  assign dropout_conceal_en_out = mode_f[`MODE_DOC_BIT];
  assign focus_four_channel_out = mode_f[`MODE_FOCUS4_BIT];
  assign rf_input_sel_out = mode_f[`MODE_RF_SEL_BIT];
  assign k_two_comp_en_out = foc_f[`FOC_K2_BIT];
  assign focus_comp_factor_out = foc_f[`FOC_BETA_MSB:`FOC_BETA_LSB];
  assign rf_stage3_gain_out = gain_f[`G3_MSB:`G3_LSB];

  // Decoded settings, registered so every output leaves a flop
  radial_mode_e track_w, track_q;
  radial_mode_decode u_track (
    .code_in(mode_f[`MODE_TRACK_MSB:`MODE_TRACK_LSB]),
    .mode_out(track_w)
  );

  wire logic [1:0] g1_code = gain_f[`G1_MSB:`G1_LSB];
  wire logic [1:0] g2_code = gain_f[`G2_MSB:`G2_LSB];
  // Forbidden stage-one code falls back to the lowest gain and is flagged
  wire logic [4:0] g1_db_w = (g1_code == 2'h1) ? `G1_DB_1 :
                             (g1_code == 2'h2) ? `G1_DB_2 : `G1_DB_0;
  wire logic [4:0] g2_db_w = (g2_code == 2'h0) ? `G2_DB_0 :
                             (g2_code == 2'h1) ? `G2_DB_1 :
                             (g2_code == 2'h2) ? `G2_DB_2 : `G2_DB_3;
  wire logic [5:0] phase_dac_w = phase_offset_src_sel_out ? sum_rf_offset_in
                                                          : left_rf_offset_in;
  wire logic shared_dac = rf_input_sel_out && !phase_offset_src_sel_out;
  wire logic [5:0] sum_dac_w = shared_dac ? phase_dac_w : sum_rf_offset_in;

  logic [4:0] g1_db_q, g2_db_q;
  logic g1_bad_q, dac_on_q;
  logic [5:0] phase_dac_q, sum_dac_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      track_q <= TRACK_PHASE_AD;
      g1_db_q <= `G1_DB_0;
      g2_db_q <= `G2_DB_0;
      g1_bad_q <= 1'b0;
      dac_on_q <= 1'b0;
      phase_dac_q <= 6'h00;
      sum_dac_q <= 6'h00;
    end
    else
    begin
      track_q <= track_w;
      g1_db_q <= g1_db_w;
      g2_db_q <= g2_db_w;
      g1_bad_q <= (g1_code == `G1_CODE_BAD);
      dac_on_q <= !foc_f[`FOC_DAC_OFF_BIT];
      phase_dac_q <= phase_dac_w;
      sum_dac_q <= sum_dac_w;
    end
  end

  assign radial_track_sel_out = track_q;
  assign rf_stage1_gain_db_out = g1_db_q;
  assign rf_stage1_code_bad_out = g1_bad_q;
  assign rf_stage2_gain_db_out = g2_db_q;
  assign focus_dac_on_out = dac_on_q;
  assign phase_offset_dac_out = phase_dac_q;
  assign sum_offset_dac_out = sum_dac_q;

  // Read channel: one answer per address, one cycle after it is taken
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire logic ar_fire = s_axi_arvalid_in && arready_q;
  wire logic rvalid_d = ar_fire || (rvalid_q && !s_axi_rready_in);
  wire logic [IDX_W-1:0] rd_idx = s_axi_araddr_in[ADDR_W-1:2];
  wire logic [15:0] status_w = {sum_dac_q, phase_dac_q, g1_bad_q, track_q};
  wire logic rd_hit = (rd_idx == IDX_W'(`IDX_POWER)) || (rd_idx == IDX_W'(`IDX_MODE)) ||
                      (rd_idx == IDX_W'(`IDX_FOCUS)) || (rd_idx == IDX_W'(`IDX_GAIN)) ||
                      (rd_idx == IDX_W'(`IDX_CMD)) || (rd_idx == IDX_W'(`IDX_STATUS));
  // The command port is write only and reads as zero
  wire logic [15:0] rd_word =
    (rd_idx == IDX_W'(`IDX_POWER)) ? {`SEL_POWER, pwr_f} :
    (rd_idx == IDX_W'(`IDX_MODE)) ? {`SEL_MODE, mode_f} :
    (rd_idx == IDX_W'(`IDX_FOCUS)) ? {`SEL_FOCUS, foc_f} :
    (rd_idx == IDX_W'(`IDX_GAIN)) ? {`SEL_GAIN, gain_f} :
    (rd_idx == IDX_W'(`IDX_STATUS)) ? status_w : 16'h0000;
  wire logic [31:0] rdata_d = ar_fire ? {16'h0000, rd_word} : rdata_q;
  wire logic [1:0] rresp_d = ar_fire ? (rd_hit ? `RESP_OKAY : `RESP_SLVERR) : rresp_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end
    else
    begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  wire logic mode_wr = cmd_wr && (cmd_sel == `SEL_MODE);
  wire logic power_wr = cmd_wr && (cmd_sel == `SEL_POWER);
  wire logic gain_wr = cmd_wr && (cmd_sel == `SEL_GAIN);

  mode_selected_a: assert property (mode_wr |=>
    mode_f == ($past(cmd_fields) & `MASK_MODE))
    else $error("mode register missed its word");
  other_kept_a: assert property (cmd_wr && !mode_wr |=> $stable(mode_f))
    else $error("mode register changed on a foreign word");
  half_word_a: assert property (do_write && !full_word |=> $stable(pwr_f) && $stable(gain_f)
    && s_axi_bresp_out == `RESP_SLVERR)
    else $error("partial word reached a register");
  power_follow_a: assert property (power_wr |=>
    pwr_f == ($past(cmd_fields) & `MASK_POWER))
    else $error("power register did not follow word");
  unused_masked_a: assert property ((mode_f & ~`MASK_MODE) == 12'h000
    && (foc_f & ~`MASK_FOCUS) == 12'h000)
    else $error("unused bit stored");
  three_beam_a: assert property (mode_wr && cmd_word[`MODE_TRACK_LSB+1:`MODE_TRACK_LSB] == 2'h3
    |=> ##1 radial_track_sel_out == TRACK_THREE_BEAM)
    else $error("three-beam mode not decoded");
  stage2_gain_a: assert property (gain_wr && cmd_word[`G2_MSB:`G2_LSB] == 2'h3
    |=> ##1 rf_stage2_gain_db_out == `G2_DB_3)
    else $error("stage two gain wrong");
  stage1_bad_a: assert property (gain_wr && cmd_word[`G1_MSB:`G1_LSB] == `G1_CODE_BAD
    |=> ##1 rf_stage1_code_bad_out && rf_stage1_gain_db_out == `G1_DB_0)
    else $error("forbidden stage one code not flagged");
  dac_share_a: assert property ($past(shared_dac) |->
    sum_offset_dac_out == phase_offset_dac_out)
    else $error("offset channels not shared");
  write_answer_a: assert property (do_write |=> s_axi_bvalid_out ##0 !s_axi_awready_out)
    else $error("write answer late");

  mode_write_c: cover property (mode_wr);
  slverr_c: cover property (s_axi_bvalid_out && s_axi_bresp_out == `RESP_SLVERR);
  status_read_c: cover property (ar_fire && rd_idx == IDX_W'(`IDX_STATUS));
  shared_dac_c: cover property (shared_dac && power_up_out);
endmodule

// >>> hw/servo_rf_pkg.sv
package servo_rf_pkg;

  typedef enum logic [2:0] {
    TRACK_PHASE_AD = 3'b000,
    TRACK_PP_AD = 3'b001,
    TRACK_PHASE_SUM = 3'b010,
    TRACK_PP_FOUR = 3'b011,
    TRACK_PHASE_DUAL = 3'b100,
    TRACK_THREE_BEAM = 3'b101,
    TRACK_UNDEFINED = 3'b110
  } radial_mode_e;

  typedef logic [11:0] field_word_t;

endpackage

// >>> tb/offset_host_model.sv
`timescale 1ns/1ns
module offset_host_model
(
  input wire logic clk_sys_in,
  input wire logic load_in,
  input wire logic [11:0] word_in,
  output logic [5:0] left_rf_offset_out,
  output logic [5:0] sum_rf_offset_out
);
  // Stands for the outer offset registers; values only move when the host loads them
  always_ff @(posedge clk_sys_in)
  begin
    if (load_in)
    begin
      left_rf_offset_out <= word_in[11:6];
      sum_rf_offset_out <= word_in[5:0];
    end
  end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ns
`include "servo_rf_cfg.svh"
module tb
  import servo_rf_pkg::*;
;
  logic clk_sys_in, reset_n_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in;
  logic [5:0] left_rf_offset_in, sum_rf_offset_in, phase_offset_dac_out, sum_offset_dac_out;
  logic second_monitor_level_sel_out, first_laser_enable_out, second_laser_enable_out;
  logic power_up_out, phase_offset_src_sel_out, radial_polarity_out, dropout_conceal_en_out;
  logic focus_four_channel_out, rf_input_sel_out, k_two_comp_en_out, focus_dac_on_out;
  radial_mode_e radial_track_sel_out;
  logic [4:0] focus_comp_factor_out, rf_stage1_gain_db_out, rf_stage2_gain_db_out;
  logic rf_stage1_code_bad_out;
  logic [3:0] rf_stage3_gain_out;
  logic offset_load;
  logic [11:0] offset_word;
  logic [5:0] off_left, off_sum;
  logic [11:0] regs [4];
  logic [11:0] mask [4];
  logic [1:0] bq [$];
  logic [1:0] rrq [$];
  logic [31:0] rdq [$];
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  servo_rf_control_regs #(.ADDR_W(8)) dut (.clk_sys_in, .reset_n_in, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .left_rf_offset_in, .sum_rf_offset_in,
    .second_monitor_level_sel_out, .first_laser_enable_out, .second_laser_enable_out,
    .power_up_out, .phase_offset_src_sel_out, .radial_polarity_out, .dropout_conceal_en_out,
    .focus_four_channel_out, .radial_track_sel_out, .rf_input_sel_out, .k_two_comp_en_out,
    .focus_dac_on_out, .focus_comp_factor_out, .rf_stage1_gain_db_out, .rf_stage1_code_bad_out,
    .rf_stage2_gain_db_out, .rf_stage3_gain_out, .phase_offset_dac_out, .sum_offset_dac_out);

  offset_host_model host (.clk_sys_in(clk_sys_in), .load_in(offset_load), .word_in(offset_word),
    .left_rf_offset_out(left_rf_offset_in), .sum_rf_offset_out(sum_rf_offset_in));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic conclude();
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic radial_mode_e track_exp(input logic [2:0] c);
    if (c[1:0] == 2'h3)
      return TRACK_THREE_BEAM;
    case (c)
      3'h0: return TRACK_PHASE_AD;
      3'h1: return TRACK_PP_AD;
      3'h4: return TRACK_PHASE_SUM;
      3'h5: return TRACK_PP_FOUR;
      3'h6: return TRACK_PHASE_DUAL;
      default: return TRACK_UNDEFINED;
    endcase
  endfunction

  // Watcher: every bus answer takes the oldest expectation noted by the driver
  always @(posedge clk_sys_in)
  begin
    if (s_axi_bvalid_out && s_axi_bready_in)
      check(32'(s_axi_bresp_out), 32'(bq.pop_front()));
    if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      check(s_axi_rdata_out, rdq.pop_front());
      check(32'(s_axi_rresp_out), 32'(rrq.pop_front()));
    end
  end

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(r);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_sys_in);
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid_in <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_ok = 1'b1;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    while (!s_axi_bvalid_out)
      @(posedge clk_sys_in);
    s_axi_bready_in <= 1'b0;
    // One idle edge so a following call never re-raises bready in this step
    @(posedge clk_sys_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rdq.push_back(d);
    rrq.push_back(r);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
      @(posedge clk_sys_in);
    while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    while (!s_axi_rvalid_out)
      @(posedge clk_sys_in);
    s_axi_rready_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic chk_all();
    logic [11:0] p, m, f, g;
    logic [5:0] ph, sd;
    logic [4:0] g1e;
    logic [31:0] st;
    p = regs[0];
    m = regs[1];
    f = regs[2];
    g = regs[3];
    ph = m[11] ? off_sum : off_left;
    sd = (m[0] && !m[11]) ? ph : off_sum;
    g1e = (g[11:10] == 2'h3) ? 5'h00 : 5'(g[11:10]) * 5'h06;
    st = {16'h0000, sd, ph, g[11:10] == 2'h3, track_exp(m[3:1])};
    @(negedge clk_sys_in);
    check(second_monitor_level_sel_out, p[3]);
    check(first_laser_enable_out, p[2]);
    check(second_laser_enable_out, p[1]);
    check(power_up_out, p[0]);
    check(phase_offset_src_sel_out, m[11]);
    check(phase_offset_dac_out, ph);
    check(radial_polarity_out, m[8]);
    check(dropout_conceal_en_out, m[5]);
    check(focus_four_channel_out, m[4]);
    check(radial_track_sel_out, track_exp(m[3:1]));
    check(rf_input_sel_out, m[0]);
    check(k_two_comp_en_out, f[11]);
    check(focus_dac_on_out, !f[10]);
    check(focus_comp_factor_out, f[9:5]);
    check(rf_stage1_gain_db_out, g1e);
    check(rf_stage1_code_bad_out, g[11:10] == 2'h3);
    check(rf_stage2_gain_db_out, 5'(g[9:8]) * 5'h06 + 5'h06);
    check(rf_stage3_gain_out, g[7:4]);
    check(sum_offset_dac_out, sd);
    @(posedge clk_sys_in);
    rd(8'h24, st, `RESP_OKAY);
  endtask

  task automatic cmd(input logic [3:0] sel, input logic [11:0] f);
    logic [31:0] d;
    d = $urandom;
    d[15:0] = {sel, f};
    wr(8'h20, d, {2'($urandom), 2'h3}, `RESP_OKAY);
    if (sel < 4'h4)
      regs[sel[1:0]] = f & mask[sel[1:0]];
    chk_all();
  endtask

  task automatic read_all();
    for (int i = 0; i < 4; i++)
      rd(8'(i * 4), {16'h0000, 4'(i), regs[i]}, `RESP_OKAY);
  endtask

  task automatic set_offsets();
    logic [11:0] w;
    w = 12'($urandom);
    offset_load <= 1'b1;
    offset_word <= w;
    @(posedge clk_sys_in);
    offset_load <= 1'b0;
    off_left = w[11:6];
    off_sum = w[5:0];
  endtask

  initial
  begin
    logic [11:0] f;
    reset_n_in = 1'b0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    s_axi_rready_in = 1'b0;
    offset_load = 1'b0;
    offset_word = 12'h000;
    regs = '{`RST_POWER, `RST_MODE, `RST_FOCUS, `RST_GAIN};
    mask = '{`MASK_POWER, `MASK_MODE, `MASK_FOCUS, `MASK_GAIN};
    void'($urandom(32'h5F34108E));
    @(posedge clk_sys_in);
    set_offsets();
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    chk_all();
    read_all();
    for (int v = 0; v < 16; v++)
      cmd(`SEL_POWER, {8'($urandom), 4'(v)});
    for (int t = 0; t < 32; t++)
    begin
      set_offsets();
      f = 12'($urandom);
      f[11] = t[4];
      f[3:1] = t[2:0];
      f[0] = t[3];
      cmd(`SEL_MODE, f);
    end
    for (int i = 0; i < 8; i++)
    begin
      f = 12'($urandom);
      f[9:5] = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : f[9:5];
      cmd(`SEL_FOCUS, f);
    end
    for (int c = 0; c < 16; c++)
    begin
      f = 12'($urandom);
      f[11:8] = 4'(c);
      cmd(`SEL_GAIN, f);
    end
    read_all();
    for (int s = 4; s < 16; s++)
      cmd(4'(s), 12'($urandom));
    wr(8'h04, 32'h0000_1FFF, 4'hF, `RESP_SLVERR);
    wr(8'h20, 32'h0000_1FFF, 4'hC, `RESP_SLVERR);
    chk_all();
    rd(8'h30, 32'h0000_0000, `RESP_SLVERR);
    rd(8'h20, 32'h0000_0000, `RESP_OKAY);
    read_all();
    repeat (2) @(posedge clk_sys_in);
    conclude();
  end
endmodule
